// [design/access_bank_address_map_defs.svh]
// Constants for the access-bank address map
// Contract
// - Access bank: bank 0 low, bank 15 high
// - Offsets below 60h bank 0, else bank 15
// - Banked access uses bank select plus offset
// - Forced access ignores bank select entirely
// - Forced access completes in one cycle
// - Extended instruction set flags modified mapping
// - RAM from 000h, never reset
// - Special registers occupy F60h to FFFh
// - Unimplemented special addresses read zero
// - Twelve-bit address, bank select on top
// - Bank select upper nibble reads zero
// - Unimplemented banks: writes dropped, reads zero
// - Full-address move ignores bank select
`ifndef ACCESS_BANK_ADDRESS_MAP_DEFS_SVH
`define ACCESS_BANK_ADDRESS_MAP_DEFS_SVH
`define ADDR_W 12
`define BANK_W 4
`define OFFS_W 8
`define DATA_W 8
`define BANK_SIZE 256
`define ACC_SPLIT 8'h60
`define BANK_LOW 4'h0
`define BANK_SFR 4'hF
`define SFR_BASE 12'hF60
`define BANK_SEL_ADDR 12'hFE0
`define STATUS_ADDR 12'hFE4
`define BANK_SEL_RST 4'h0
`define STAT_EXT_BIT 12
`define AV_ADDR_W 12
`define AV_DATA_W 32
`endif

// [design/access_bank_address_map_pkg.sv]
// Types for the access-bank address map
package access_bank_address_map_pkg;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_DONE = 2'b10
   } bus_state_t;
endpackage

// [design/access_bank_address_map.sv]
// Data-memory address map with bank select register and access bank
`timescale 1ns/1ps
`default_nettype none
`include "access_bank_address_map_defs.svh"
module access_bank_address_map #(
   parameter int GPR_BANKS = 1
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic core_req,
   input wire logic core_wr,
   input wire logic core_access_sel,
   input wire logic core_full_move,
   input wire logic [`OFFS_W-1:0] core_offset,
   input wire logic [`ADDR_W-1:0] core_full_addr,
   input wire logic [`DATA_W-1:0] core_wdata,
   input wire logic core_load_bank,
   input wire logic [`BANK_W-1:0] core_bank_literal,
   input wire logic extended_instruction_enable,
   output logic [`ADDR_W-1:0] data_addr_reg,
   output logic [`DATA_W-1:0] core_rdata_reg,
   output logic core_done_reg,
   output logic alt_map_reg,
   input wire logic [`AV_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [`AV_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [`AV_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest
);
   localparam int RAM_BYTES = GPR_BANKS * `BANK_SIZE;

   // Bank 15 holds the special registers, so RAM may fill at most 15 banks
   if (GPR_BANKS < 1 || GPR_BANKS > 15) begin : g_bad_banks
      $error("GPR_BANKS must lie in 1..15");
   end

   access_bank_address_map_pkg::bus_state_t bus_state_reg;
   access_bank_address_map_pkg::bus_state_t bus_state_next;
   logic [`BANK_W-1:0] bank_select_reg;
   logic [`BANK_W-1:0] bank_select_next;
   logic [`DATA_W-1:0] ram [RAM_BYTES];
   logic [`DATA_W-1:0] core_rdata_next;
   logic [`AV_DATA_W-1:0] avs_readdata_next;

   // Address forming
   wire logic low_half = core_offset < `ACC_SPLIT;
   wire logic [`BANK_W-1:0] access_bank =
      low_half ? `BANK_LOW : `BANK_SFR;
   wire logic [`BANK_W-1:0] sel_bank =
      core_access_sel ? bank_select_reg : access_bank;
   wire logic [`ADDR_W-1:0] eff_addr = core_full_move ? core_full_addr
      : {sel_bank, core_offset};

   // Decode of the effective address
   wire logic [`BANK_W-1:0] eff_bank = eff_addr[`ADDR_W-1:`OFFS_W];
   wire logic gpr_hit = eff_addr < `SFR_BASE
      && 32'(eff_bank) < GPR_BANKS;
   wire logic sfr_hit = eff_addr >= `SFR_BASE;
   wire logic bsr_hit = eff_addr == `BANK_SEL_ADDR;
   wire logic core_rd_unimpl = !gpr_hit && !bsr_hit;
   wire logic core_bsr_wr = core_req && core_wr && bsr_hit;
   wire logic core_ram_wr = core_req && core_wr && gpr_hit;
   wire logic [`DATA_W-1:0] bsr_byte = {4'h0, bank_select_reg};
   wire logic [$clog2(RAM_BYTES)-1:0] ram_idx =
      eff_addr[$clog2(RAM_BYTES)-1:0];

   always_comb begin
      core_rdata_next = '0;
      if (gpr_hit) begin
         core_rdata_next = ram[ram_idx];
      end else if (bsr_hit) begin
         core_rdata_next = bsr_byte;
      end
   end

   // Bus slave decode
   wire logic av_req = avs_read || avs_write;
   wire logic av_bsr = avs_address == `BANK_SEL_ADDR;
   wire logic av_stat = avs_address == `STATUS_ADDR;
   wire logic av_commit =
      bus_state_reg == access_bank_address_map_pkg::BUS_DONE;
   wire logic av_bsr_wr = av_commit && avs_write && av_bsr
      && avs_byteenable[0];
   wire logic [`AV_DATA_W-1:0] stat_word =
      {19'h0, alt_map_reg, data_addr_reg};

   always_comb begin
      avs_readdata_next = avs_readdata;
      if (bus_state_reg == access_bank_address_map_pkg::BUS_IDLE
          && avs_read) begin
         avs_readdata_next = '0;
         if (av_bsr) begin
            avs_readdata_next = {24'h0, bsr_byte};
         end else if (av_stat) begin
            avs_readdata_next = stat_word;
         end
      end
   end

   always_comb begin
      bus_state_next = bus_state_reg;
      unique case (bus_state_reg)
         access_bank_address_map_pkg::BUS_IDLE: begin
            if (av_req) begin
               bus_state_next = access_bank_address_map_pkg::BUS_DONE;
            end
         end
         access_bank_address_map_pkg::BUS_DONE: begin
            bus_state_next = access_bank_address_map_pkg::BUS_IDLE;
         end
         default: begin
            bus_state_next = access_bank_address_map_pkg::BUS_IDLE;
         end
      endcase
   end

   // Core access wins over a bus write in the same cycle
   always_comb begin
      bank_select_next = bank_select_reg;
      if (core_load_bank) begin
         bank_select_next = core_bank_literal;
      end else if (core_bsr_wr) begin
         bank_select_next = core_wdata[`BANK_W-1:0];
      end else if (av_bsr_wr) begin
         bank_select_next = avs_writedata[`BANK_W-1:0];
      end
   end

   // Waitrequest drops for exactly the committing cycle
   wire logic waitrequest_next =
      !(bus_state_reg == access_bank_address_map_pkg::BUS_IDLE && av_req);

   always_ff @(posedge clock) begin
      if (srst) begin
         bus_state_reg <= access_bank_address_map_pkg::BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end else begin
         bus_state_reg <= bus_state_next;
         avs_waitrequest <= waitrequest_next;
         avs_readdata <= avs_readdata_next;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         bank_select_reg <= `BANK_SEL_RST;
         data_addr_reg <= '0;
         core_rdata_reg <= '0;
         core_done_reg <= 1'b0;
         alt_map_reg <= 1'b0;
      end else begin
         bank_select_reg <= bank_select_next;
         core_done_reg <= core_req;
         alt_map_reg <= extended_instruction_enable;
         if (core_req) begin
            data_addr_reg <= eff_addr;
            core_rdata_reg <= core_rdata_next;
         end
      end
   end

   // RAM keeps its contents through reset
   always_ff @(posedge clock) begin
      if (core_ram_wr) begin
         ram[ram_idx] <= core_wdata;
      end
   end

   a_access_low_map: assert property (@(posedge clock) disable iff (srst)
      core_req && !core_full_move && !core_access_sel
      && core_offset < `ACC_SPLIT
      |=> data_addr_reg == {`BANK_LOW, $past(core_offset)})
      else $error("low access half not in bank 0");

   a_access_high_map: assert property (@(posedge clock) disable iff (srst)
      core_req && !core_full_move && !core_access_sel
      && core_offset >= `ACC_SPLIT
      |=> data_addr_reg[`ADDR_W-1:`OFFS_W] == `BANK_SFR)
      else $error("high access half not in bank 15");

   a_banked_map: assert property (@(posedge clock) disable iff (srst)
      core_req && !core_full_move && core_access_sel
      |=> data_addr_reg == {$past(bank_select_reg), $past(core_offset)})
      else $error("banked address wrong");

   a_forced_ignores_bank: assert property (@(posedge clock) disable iff (srst)
      core_req && !core_full_move && !core_access_sel
      && bank_select_reg != `BANK_LOW && bank_select_reg != `BANK_SFR
      |=> data_addr_reg[`ADDR_W-1:`OFFS_W] != $past(bank_select_reg))
      else $error("forced access used bank select");

   a_single_cycle: assert property (@(posedge clock) disable iff (srst)
      core_req |=> core_done_reg ##1 (core_done_reg == $past(core_req)))
      else $error("access not done in one cycle");

   a_ext_flag: assert property (@(posedge clock) disable iff (srst)
      $rose(extended_instruction_enable) |=> alt_map_reg)
      else $error("alternate map flag missed");

   a_unimpl_zero: assert property (@(posedge clock) disable iff (srst)
      core_req && core_rd_unimpl |=> core_rdata_reg == '0)
      else $error("unimplemented read not zero");

   a_bsr_upper_zero: assert property (@(posedge clock) disable iff (srst)
      avs_read && av_bsr && !avs_waitrequest |-> avs_readdata[7:4] == 4'h0)
      else $error("bank select upper nibble not zero");

   a_full_move: assert property (@(posedge clock) disable iff (srst)
      core_req && core_full_move |=> data_addr_reg == $past(core_full_addr))
      else $error("full move address altered");

   a_sfr_region: assert property (@(posedge clock) disable iff (srst)
      core_req && sfr_hit |-> eff_bank == `BANK_SFR)
      else $error("special region outside bank 15");

   a_bus_answer: assert property (@(posedge clock) disable iff (srst)
      av_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle");

   c_forced_sfr: cover property (@(posedge clock) disable iff (srst)
      core_req && !core_access_sel && !low_half);
   c_banked_write: cover property (@(posedge clock) disable iff (srst)
      core_req && core_access_sel && core_wr && gpr_hit);
   c_bus_bsr_write: cover property (@(posedge clock) disable iff (srst)
      av_bsr_wr);
   c_full_move: cover property (@(posedge clock) disable iff (srst)
      core_req && core_full_move);
   c_empty_bank_read: cover property (@(posedge clock) disable iff (srst)
      core_req && !core_wr && eff_addr < `SFR_BASE && !gpr_hit);

   // Bank select write paths and their priority
   a_load_bank_wins: assert property (@(posedge clock) disable iff (srst)
      core_load_bank
      |=> bank_select_reg == $past(core_bank_literal))
      else $error("bank literal load lost");

   a_core_bank_write: assert property (@(posedge clock) disable iff (srst)
      core_bsr_wr && !core_load_bank
      |=> bank_select_reg == $past(core_wdata[`BANK_W-1:0]))
      else $error("core bank select write lost");

   a_bus_bank_write: assert property (@(posedge clock) disable iff (srst)
      av_bsr_wr && !core_load_bank && !core_bsr_wr
      |=> bank_select_reg == $past(avs_writedata[`BANK_W-1:0]))
      else $error("bus bank select write lost");

   a_core_bsr_upper: assert property (@(posedge clock) disable iff (srst)
      core_req && !core_wr && bsr_hit
      |=> core_rdata_reg[`DATA_W-1:`BANK_W] == '0)
      else $error("core read of bank select upper bits not zero");

   // Core port timing
   a_done_needs_req: assert property (@(posedge clock) disable iff (srst)
      !core_req |=> !core_done_reg)
      else $error("done without a request");

   a_addr_holds: assert property (@(posedge clock) disable iff (srst)
      !core_req |=> $stable(data_addr_reg))
      else $error("address changed without a request");

   a_high_offset_kept: assert property (@(posedge clock) disable iff (srst)
      core_req && !core_full_move && !core_access_sel
      |=> data_addr_reg[`OFFS_W-1:0] == $past(core_offset))
      else $error("access offset altered");

   // Empty RAM banks read zero whatever was written there
   a_empty_bank_zero: assert property (@(posedge clock) disable iff (srst)
      core_req && eff_addr < `SFR_BASE && !gpr_hit
      |=> core_rdata_reg == '0)
      else $error("empty bank read not zero");

   a_alt_follows: assert property (@(posedge clock) disable iff (srst)
      1'b1 |=> alt_map_reg == $past(extended_instruction_enable))
      else $error("alternate map flag lags");

   // Bus slave timing
   a_bus_release: assert property (@(posedge clock) disable iff (srst)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low two cycles");

   a_readdata_holds: assert property (@(posedge clock) disable iff (srst)
      !(avs_read && bus_state_reg == access_bank_address_map_pkg::BUS_IDLE)
      |=> $stable(avs_readdata))
      else $error("read data changed without a read");
endmodule // access_bank_address_map
`default_nettype wire

// [bench/core_model.sv]
// Core-side model issuing data accesses and bank loads
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input wire logic clock,
   output logic req,
   output logic wr,
   output logic sel,
   output logic fm,
   output logic [7:0] off,
   output logic [11:0] fa,
   output logic [7:0] wd,
   output logic lb,
   output logic [3:0] lit
);
   initial {req, wr, sel, fm, lb, off, fa, wd, lit} = '0;
   // One access; idle gaps before it model slow decode
   task automatic acc(input logic w, s, m, input logic [7:0] o,
         input logic [11:0] a, input logic [7:0] d, input int gap);
      repeat (gap + 1) @(posedge clock);
      req <= 1'b1;
      wr <= w;
      sel <= s;
      fm <= m;
      off <= o;
      fa <= a;
      wd <= d;
      @(posedge clock);
      req <= 1'b0;
      // Offset and data lines do not keep their last value once released; fa does
      off <= ~o;
      wd <= ~d;
   endtask
   task automatic bank(input logic [3:0] v);
      @(posedge clock);
      lb <= 1'b1;
      lit <= v;
      @(posedge clock);
      lb <= 1'b0;
   endtask
endmodule // core_model
`default_nettype wire

// [bench/access_bank_address_map_tb.sv]
// Self-checking bench for the access-bank address map
`timescale 1ns/1ps
`default_nettype none
`include "access_bank_address_map_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
$display("wrong value %s exp %h got %h", n, e, g); end end
module access_bank_address_map_tb;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic req, wr, sel, fm, lb, dn, am, ar, aw, awr;
   logic ext = 1'b0;
   logic [7:0] off, wd, rd;
   logic [11:0] fa, da;
   logic [11:0] aa = '0;
   logic [3:0] lit;
   logic [3:0] bk = 4'h0;
   logic [31:0] awd = '0;
   logic [31:0] ard, q;
   logic [7:0] d;
   int fails = 0;
   int checks = 0;
   initial {ar, aw} = 2'b00;
   initial forever #50 clock = ~clock;
   core_model u_core (.clock(clock), .req(req), .wr(wr), .sel(sel),
      .fm(fm), .off(off), .fa(fa), .wd(wd), .lb(lb), .lit(lit));
   access_bank_address_map dut (.clock(clock), .srst(srst),
      .core_req(req), .core_wr(wr), .core_access_sel(sel),
      .core_full_move(fm), .core_offset(off), .core_full_addr(fa),
      .core_wdata(wd), .core_load_bank(lb), .core_bank_literal(lit),
      .extended_instruction_enable(ext), .data_addr_reg(da),
      .core_rdata_reg(rd), .core_done_reg(dn), .alt_map_reg(am),
      .avs_address(aa), .avs_read(ar), .avs_write(aw),
      .avs_writedata(awd), .avs_byteenable(4'hF),
      .avs_readdata(ard), .avs_waitrequest(awr));
   function automatic logic [11:0] ea(logic m, s, logic [3:0] b,
         logic [7:0] o, logic [11:0] f);
      if (m) return f;
      if (s) return {b, o};
      return (o < 8'h60) ? {4'h0, o} : {4'hF, o};
   endfunction
   task automatic bus(input logic w, input logic [11:0] a,
         input logic [31:0] wv, output logic [31:0] rv);
      int n;
      n = 0;
      @(posedge clock);
      ar <= !w;
      aw <= w;
      aa <= a;
      awd <= wv;
      @(posedge clock);
      while (awr !== 1'b0 && n < 50) begin
         @(posedge clock);
         n++;
      end
      if (n >= 50) fails++;
      rv = ard;
      ar <= 1'b0;
      aw <= 1'b0;
   endtask
   task automatic go(input logic w, s, m, input logic [7:0] o,
         input logic [11:0] f, input logic [7:0] dv);
      u_core.acc(w, s, m, o, f, dv, $urandom_range(2));
      #1;
      `CHK("done", 1'b1, dn)
      `CHK("addr", ea(m, s, bk, o, f), da)
      `CHK("alt map", ext, am)
   endtask
   task end_sim;
      if (fails == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Generous bound; the tests need well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      end_sim();
   end
   initial begin
      void'($urandom(32'hBDA3));
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      bus(1'b0, 12'hFE0, 32'h0, q);
      `CHK("bank reset", 32'h0, q)
      bus(1'b1, 12'hFE0, 32'hFFFFFFA5, q);
      bus(1'b0, 12'hFE0, 32'h0, q);
      `CHK("bank upper", 32'h5, q)
      bk = 4'h5;
      d = 8'($urandom);
      go(1'b1, 1'b0, 1'b0, 8'h10, 12'h0, d);
      u_core.bank(4'h0);
      bk = 4'h0;
      go(1'b0, 1'b1, 1'b0, 8'h10, 12'h0, 8'h0);
      `CHK("ram", d, rd)
      u_core.bank(4'h3);
      bk = 4'h3;
      go(1'b1, 1'b1, 1'b0, 8'h10, 12'h0, ~d);
      go(1'b0, 1'b1, 1'b0, 8'h10, 12'h0, 8'h0);
      `CHK("no bank", 8'h00, rd)
      go(1'b0, 1'b0, 1'b1, 8'h00, 12'h010, 8'h0);
      `CHK("full move", d, rd)
      go(1'b0, 1'b0, 1'b1, 8'h00, 12'hF61, 8'h0);
      `CHK("empty sfr", 8'h00, rd)
      go(1'b0, 1'b0, 1'b0, 8'hE0, 12'h0, 8'h0);
      `CHK("forced sfr", 8'h03, rd)
      bus(1'b0, 12'hFE4, 32'h0, q);
      `CHK("status", {19'h0, ext, 12'hFE0}, q)
      go(1'b1, 1'b0, 1'b0, 8'hE0, 12'h0, 8'hA7);
      bk = 4'h7;
      go(1'b0, 1'b0, 1'b0, 8'hE0, 12'h0, 8'h0);
      `CHK("core bank", 8'h07, rd)
      bus(1'b0, 12'h100, 32'h0, q);
      `CHK("unmapped", 32'h0, q)
      repeat (40) begin
         if ($urandom_range(3) == 0) begin
            bus(1'b1, 12'hFE0, $urandom, q);
            bk = awd[3:0];
            bus(1'b0, 12'hFE0, 32'h0, q);
            `CHK("bank rd", {28'h0, bk}, q)
         end
         @(posedge clock);
         ext <= 1'($urandom);
         go(1'b0, 1'($urandom), 1'($urandom), 8'($urandom),
            12'($urandom), 8'h0);
      end
      end_sim();
   end
endmodule // access_bank_address_map_tb
`default_nettype wire
